// ### rtl/rtcc_pkg.sv
// Package: shared types, register map and constants of the calendar timekeeper
`default_nettype none
package rtcc_pkg;

	// ==========================================================
	// Calendar time record, also used for the alarm set-points
	typedef struct packed {
		logic [7:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rtcc_time_t;

	// Bus-side signals of one register access
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} rtcc_bus_req_t;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] CUR_SECOND_OFF = 8'h00;
	localparam logic [7:0] CUR_MINUTE_OFF = 8'h04;
	localparam logic [7:0] CUR_HOUR_OFF = 8'h08;
	localparam logic [7:0] CUR_DAY_OFF = 8'h0c;
	localparam logic [7:0] CUR_MONTH_OFF = 8'h10;
	localparam logic [7:0] YEAR_COUNT_OFF = 8'h14;
	localparam logic [7:0] PACKED_SNAPSHOT_OFF = 8'h18;
	localparam logic [7:0] ALARM_SECOND_OFF = 8'h1c;
	localparam logic [7:0] ALARM_MINUTE_OFF = 8'h20;
	localparam logic [7:0] ALARM_HOUR_OFF = 8'h24;
	localparam logic [7:0] ALARM_DAY_OFF = 8'h28;
	localparam logic [7:0] ALARM_MONTH_OFF = 8'h2c;
	localparam logic [7:0] ALARM_YEAR_OFF = 8'h30;
	localparam logic [7:0] ALARM_FIELD_EN_OFF = 8'h34;
	localparam logic [7:0] CONTROL_OFF = 8'h38;

	// ==========================================================
	// Field positions
	localparam int SNAP_YEAR_LSB = 26;
	localparam int SNAP_MONTH_LSB = 22;
	localparam int SNAP_DAY_LSB = 17;
	localparam int SNAP_HOUR_LSB = 12;
	localparam int SNAP_MINUTE_LSB = 6;
	localparam int SNAP_SECOND_LSB = 0;
	localparam int CTRL_IRQ_EN_BIT = 0;
	localparam int CTRL_PENDING_BIT = 1;
	localparam int CTRL_PRESET_BIT = 2;
	localparam int FIELD_EN_W = 6;

	// ==========================================================
	// Field limits and reset values
	localparam logic [5:0] SECOND_MAX = 6'h3b;
	localparam logic [5:0] MINUTE_MAX = 6'h3b;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [3:0] MONTH_MAX = 4'hc;
	localparam logic [3:0] MONTH_FEB = 4'h2;
	localparam logic [4:0] DAY_FIRST = 5'h01;
	localparam logic [3:0] MONTH_FIRST = 4'h1;
	localparam rtcc_time_t TIME_POR = '{8'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00};
	localparam logic [5:0] FIELD_EN_POR = 6'h00;

	// ==========================================================
	// Timing: crystal edges per second
	localparam int XTAL_HZ = 32768;
	localparam int PRESC_W_DEF = $clog2(XTAL_HZ);

endpackage : rtcc_pkg
`default_nettype wire

// ### rtl/rtcc_cal.sv
// Calendar next-second computation with carries and month lengths
`default_nettype none
module rtcc_cal
(
	input wire rtcc_pkg::rtcc_time_t cur_i,
	output var rtcc_pkg::rtcc_time_t nxt_o
);

	logic leap;
	logic [4:0] month_len;

	// ==========================================================
	// Month length, leap every fourth year offset
	always_comb
	begin
		leap = (cur_i.year[1:0] == 2'b00);
		unique case (cur_i.month)
			4'h4, 4'h6, 4'h9, 4'hb: month_len = 5'h1e;
			rtcc_pkg::MONTH_FEB: month_len = leap ? 5'h1d : 5'h1c;
			default: month_len = 5'h1f;
		endcase
	end

	// ==========================================================
	// Ripple carry through all fields
	always_comb
	begin
		nxt_o = cur_i;
		if (cur_i.second < rtcc_pkg::SECOND_MAX)
			nxt_o.second = cur_i.second + 6'h01;
		else
		begin
			nxt_o.second = 6'h00;
			if (cur_i.minute < rtcc_pkg::MINUTE_MAX)
				nxt_o.minute = cur_i.minute + 6'h01;
			else
			begin
				nxt_o.minute = 6'h00;
				if (cur_i.hour < rtcc_pkg::HOUR_MAX)
					nxt_o.hour = cur_i.hour + 5'h01;
				else
				begin
					nxt_o.hour = 5'h00;
					if (cur_i.day < month_len)
						nxt_o.day = cur_i.day + 5'h01;
					else
					begin
						nxt_o.day = rtcc_pkg::DAY_FIRST;
						if (cur_i.month < rtcc_pkg::MONTH_MAX)
							nxt_o.month = cur_i.month + 4'h1;
						else
						begin
							nxt_o.month = rtcc_pkg::MONTH_FIRST;
							nxt_o.year = cur_i.year + 8'h01;
						end
					end
				end
			end
		end
	end

endmodule // rtcc_cal
`default_nettype wire

// ### rtl/rtcc_top.sv
// Calendar timekeeper with alarm, APB register slave and crystal prescaler
`default_nettype none
module rtcc_top
#(
	parameter int PRESC_W = rtcc_pkg::PRESC_W_DEF
)
(
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic por_b_i,
	input wire logic ce_i,
	input wire logic xtal_32k_i,
	input wire logic apb_lock_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic alarm_irq_o,
	output logic wake_o
);

	// ==========================================================
	// Elaboration check
	if (PRESC_W < 2 || PRESC_W > 24)
	begin : g_chk
		$error("PRESC_W out of range");
	end

	rtcc_pkg::rtcc_bus_req_t req;
	assign req = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};

	// State
	logic xs1_r, xs2_r, xs3_r;
	logic [PRESC_W-1:0] presc_r, presc_nxt;
	rtcc_pkg::rtcc_time_t time_r, time_nxt, time_inc, alarm_r, alarm_nxt;
	logic [5:0] field_en_r, field_en_nxt;
	logic pending_r, pending_nxt, irq_en_r, irq_en_nxt;
	logic tick_d_r, irq_r, irq_nxt, wake_r, wake_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic xtal_rise, tick, wr, preset, alarm_hit, mapped;
	logic [5:0] field_eq, field_ok;
	logic [31:0] snap, rd_word;

	// ==========================================================
	// Decode and packed snapshot
	assign xtal_rise = xs2_r & ~xs3_r;
	assign tick = xtal_rise & (presc_r == {PRESC_W{1'b1}});
	assign wr = req.sel & req.enable & req.write & pready_r & ~apb_lock_i;
	assign preset = wr & (req.addr == rtcc_pkg::CONTROL_OFF)
		& req.wdata[rtcc_pkg::CTRL_PRESET_BIT];
	assign snap = (32'(time_r.year[5:0]) << rtcc_pkg::SNAP_YEAR_LSB)
		| (32'(time_r.month) << rtcc_pkg::SNAP_MONTH_LSB)
		| (32'(time_r.day) << rtcc_pkg::SNAP_DAY_LSB)
		| (32'(time_r.hour) << rtcc_pkg::SNAP_HOUR_LSB)
		| (32'(time_r.minute) << rtcc_pkg::SNAP_MINUTE_LSB)
		| (32'(time_r.second) << rtcc_pkg::SNAP_SECOND_LSB);

	// Calendar increment
	rtcc_cal u_cal
	(
		.cur_i(time_r),
		.nxt_o(time_inc)
	);

	// ==========================================================
	// Alarm compare, field equalities
	assign field_eq = {time_r.year == alarm_r.year, time_r.month == alarm_r.month,
		time_r.day == alarm_r.day, time_r.hour == alarm_r.hour,
		time_r.minute == alarm_r.minute, time_r.second == alarm_r.second};

	for (genvar i = 0; i < rtcc_pkg::FIELD_EN_W; i++)
	begin : g_field
		assign field_ok[i] = ~field_en_r[i] | field_eq[i];
	end

	assign alarm_hit = tick_d_r & (&field_ok);

	// ==========================================================
	// Crystal synchroniser and prescaler
	always_comb
	begin
		presc_nxt = presc_r;
		if (preset)
			presc_nxt = {PRESC_W{1'b1}};
		else if (xtal_rise)
			presc_nxt = presc_r + 1'b1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!por_b_i)
		begin
			xs1_r <= 1'b0;
			xs2_r <= 1'b0;
			xs3_r <= 1'b0;
			presc_r <= '0;
			tick_d_r <= 1'b0;
		end
		else if (ce_i)
		begin
			xs1_r <= xtal_32k_i;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
			presc_r <= presc_nxt;
			tick_d_r <= tick;
		end
	end

	// ==========================================================
	// Time, alarm and control registers
	always_comb
	begin
		time_nxt = tick ? time_inc : time_r;
		alarm_nxt = alarm_r;
		field_en_nxt = field_en_r;
		irq_en_nxt = irq_en_r;
		if (wr)
		begin
			unique case (req.addr)
				rtcc_pkg::CUR_SECOND_OFF: time_nxt.second = req.wdata[5:0];
				rtcc_pkg::CUR_MINUTE_OFF: time_nxt.minute = req.wdata[5:0];
				rtcc_pkg::CUR_HOUR_OFF: time_nxt.hour = req.wdata[4:0];
				rtcc_pkg::CUR_DAY_OFF: time_nxt.day = req.wdata[4:0];
				rtcc_pkg::CUR_MONTH_OFF: time_nxt.month = req.wdata[3:0];
				rtcc_pkg::YEAR_COUNT_OFF: time_nxt.year = req.wdata[7:0];
				rtcc_pkg::ALARM_SECOND_OFF: alarm_nxt.second = req.wdata[5:0];
				rtcc_pkg::ALARM_MINUTE_OFF: alarm_nxt.minute = req.wdata[5:0];
				rtcc_pkg::ALARM_HOUR_OFF: alarm_nxt.hour = req.wdata[4:0];
				rtcc_pkg::ALARM_DAY_OFF: alarm_nxt.day = req.wdata[4:0];
				rtcc_pkg::ALARM_MONTH_OFF: alarm_nxt.month = req.wdata[3:0];
				rtcc_pkg::ALARM_YEAR_OFF: alarm_nxt.year = req.wdata[7:0];
				rtcc_pkg::ALARM_FIELD_EN_OFF: field_en_nxt = req.wdata[5:0];
				rtcc_pkg::CONTROL_OFF: irq_en_nxt = req.wdata[rtcc_pkg::CTRL_IRQ_EN_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!por_b_i)
		begin
			time_r <= rtcc_pkg::TIME_POR;
			alarm_r <= rtcc_pkg::TIME_POR;
			field_en_r <= rtcc_pkg::FIELD_EN_POR;
			irq_en_r <= 1'b0;
		end
		else if (ce_i)
		begin
			time_r <= time_nxt;
			alarm_r <= alarm_nxt;
			field_en_r <= field_en_nxt;
			irq_en_r <= irq_en_nxt;
		end
	end

	// ==========================================================
	// Pending flag, interrupt and wake
	always_comb
	begin
		pending_nxt = pending_r;
		if (wr && req.addr == rtcc_pkg::CONTROL_OFF && req.wdata[rtcc_pkg::CTRL_PENDING_BIT])
			pending_nxt = 1'b0;
		if (alarm_hit)
			pending_nxt = 1'b1;
		irq_nxt = pending_nxt & irq_en_nxt;
		wake_nxt = alarm_hit;
	end

	// Status flops
	always_ff @(posedge ref_clk_i)
	begin
		if (!por_b_i)
		begin
			pending_r <= 1'b0;
			irq_r <= 1'b0;
			wake_r <= 1'b0;
		end
		else if (ce_i)
		begin
			pending_r <= pending_nxt;
			irq_r <= irq_nxt;
			wake_r <= wake_nxt;
		end
	end

	// ==========================================================
	// APB read mux and handshake
	always_comb
	begin
		mapped = 1'b1;
		unique case (req.addr)
			rtcc_pkg::CUR_SECOND_OFF: rd_word = 32'(time_r.second);
			rtcc_pkg::CUR_MINUTE_OFF: rd_word = 32'(time_r.minute);
			rtcc_pkg::CUR_HOUR_OFF: rd_word = 32'(time_r.hour);
			rtcc_pkg::CUR_DAY_OFF: rd_word = 32'(time_r.day);
			rtcc_pkg::CUR_MONTH_OFF: rd_word = 32'(time_r.month);
			rtcc_pkg::YEAR_COUNT_OFF: rd_word = 32'(time_r.year);
			rtcc_pkg::PACKED_SNAPSHOT_OFF: rd_word = snap;
			rtcc_pkg::ALARM_SECOND_OFF: rd_word = 32'(alarm_r.second);
			rtcc_pkg::ALARM_MINUTE_OFF: rd_word = 32'(alarm_r.minute);
			rtcc_pkg::ALARM_HOUR_OFF: rd_word = 32'(alarm_r.hour);
			rtcc_pkg::ALARM_DAY_OFF: rd_word = 32'(alarm_r.day);
			rtcc_pkg::ALARM_MONTH_OFF: rd_word = 32'(alarm_r.month);
			rtcc_pkg::ALARM_YEAR_OFF: rd_word = 32'(alarm_r.year);
			rtcc_pkg::ALARM_FIELD_EN_OFF: rd_word = 32'(field_en_r);
			rtcc_pkg::CONTROL_OFF: rd_word = 32'({1'b0, pending_r, irq_en_r});
			default:
			begin
				rd_word = 32'h0000_0000;
				mapped = 1'b0;
			end
		endcase
		// Setup phase captures answer, access phase completes
		pready_nxt = req.sel & ~req.enable;
		pslverr_nxt = req.sel & ~req.enable & ~mapped;
		prdata_nxt = (req.sel & ~req.enable & ~req.write) ? rd_word : 32'h0000_0000;
	end

	// Bus flops, cleared by system reset
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign alarm_irq_o = irq_r;
	assign wake_o = wake_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i || !por_b_i);

	sequence s_snap_read;
		ce_i && req.sel && !req.enable && !req.write && req.addr == rtcc_pkg::PACKED_SNAPSHOT_OFF;
	endsequence
	property p_snap;
		s_snap_read |=> prdata_o == $past(snap);
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot read wrong");

	property p_snap_fields;
		snap[31:26] == time_r.year[5:0] && snap[25:22] == time_r.month
			&& snap[21:17] == time_r.day && snap[16:12] == time_r.hour;
	endproperty
	a_snap_fields: assert property (p_snap_fields) else $error("snapshot layout");

	property p_preset_zero;
		ce_i && req.sel && !req.enable && req.addr == rtcc_pkg::CONTROL_OFF |=> !prdata_o[2];
	endproperty
	a_preset_zero: assert property (p_preset_zero) else $error("preset bit read one");

	sequence s_preset;
		ce_i && preset;
	endsequence
	// Preset count is held until the next crystal edge arrives
	property p_preset;
		s_preset ##1 (ce_i && !xtal_rise) |=> presc_r == {PRESC_W{1'b1}};
	endproperty
	a_preset: assert property (p_preset) else $error("preset count lost");
	property p_preset_cnt;
		s_preset |=> presc_r == {PRESC_W{1'b1}};
	endproperty
	a_preset_cnt: assert property (p_preset_cnt) else $error("preset not loaded");

	property p_pending;
		ce_i && alarm_hit |=> pending_r ##1 (pending_r || $past(wr));
	endproperty
	a_pending: assert property (p_pending) else $error("pending not held");

	property p_irq;
		alarm_irq_o |-> irq_en_r && pending_r;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without enable");

	property p_wake;
		ce_i && alarm_hit |=> wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake missing");

	property p_hit_tick;
		alarm_hit |-> $past(tick);
	endproperty
	a_hit_tick: assert property (p_hit_tick) else $error("compare off tick");

	property p_lock;
		ce_i && apb_lock_i && !tick |=> $stable(time_r.year) && $stable(alarm_r);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write landed");

	property p_sec;
		ce_i && tick && !wr && time_r.second < rtcc_pkg::SECOND_MAX
			|=> time_r.second == $past(time_r.second) + 6'h01;
	endproperty
	a_sec: assert property (p_sec) else $error("second not advanced");

	property p_match;
		alarm_hit |-> (!field_en_r[5] || time_r.year == alarm_r.year)
			&& (!field_en_r[0] || time_r.second == alarm_r.second);
	endproperty
	a_match: assert property (p_match) else $error("enabled field mismatched");

endmodule // rtcc_top
`default_nettype wire

// ### testbench/rtcc_top_tb.sv
// Self-checking bench for the calendar timekeeper register block
`default_nettype none
module rtcc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic e;
	} rtcc_note_t;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic por_b_i = 1'b0;
	logic ce_i = 1'b1;
	logic xtal_32k_i = 1'b0;
	logic apb_lock_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, alarm_irq_o, wake_o;
	rtcc_note_t notes[$];
	rtcc_note_t note;
	int n_mismatch = 0;
	int cmp_count = 0;
	int wake_cnt = 0;
	int wake_exp = 0;
	int cycles = 0;
	localparam int TIMEOUT = 5000;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	int wd[6] = '{6, 6, 5, 5, 4, 8};
	int lim[6] = '{60, 60, 24, 31, 12, 256};
	logic [31:0] av[6];
	logic [31:0] tv[6] = '{32'h1f, 32'h14, 32'h07, 32'h0a, 32'h05, 32'h30};

	// Short prescaler so one second is 16 crystal edges
	rtcc_top #(.PRESC_W(4)) uut
	(
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i), .ce_i(ce_i),
		.xtal_32k_i(xtal_32k_i), .apb_lock_i(apb_lock_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .alarm_irq_o(alarm_irq_o), .wake_o(wake_o)
	);

	// ==========================================================
	// Clock and helpers
	always #20 ref_clk_i = ~ref_clk_i;

	task automatic miss(input logic [31:0] got, input logic [31:0] exp);
		$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		n_mismatch++;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
			miss(got, exp);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One register access: setup, access, hold until ready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic [31:0] msk, input logic err);
		int k;
		@(posedge ref_clk_i);
		#1;
		psel_i = 1'b1;
		pwrite_i = wr;
		paddr_i = a;
		pwdata_i = d;
		@(posedge ref_clk_i);
		#1;
		penable_i = 1'b1;
		notes.push_back('{exp, msk, err});
		k = 0;
		// Hold the request until the edge at which ready is sampled high
		while (pready_o !== 1'b1 && k < 4)
		begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end
		@(posedge ref_clk_i);
		#1;
		psel_i = 1'b0;
		penable_i = 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0000_0000, ALL, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, exp, ALL, 1'b0);
	endtask

	// Preset the prescaler, then one crystal rising edge gives a tick
	task automatic tick(input logic [31:0] ctrl);
		wr(8'h38, ctrl | 32'h0000_0004);
		#1;
		xtal_32k_i = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		#1;
		xtal_32k_i = 1'b0;
		repeat (10) @(posedge ref_clk_i);
	endtask

	task automatic set_time(input logic [31:0] y, mo, d, h, mi, s);
		wr(8'h00, s);
		wr(8'h04, mi);
		wr(8'h08, h);
		wr(8'h0c, d);
		wr(8'h10, mo);
		wr(8'h14, y);
	endtask

	function automatic logic [31:0] snap(input logic [7:0] y, input logic [3:0] mo,
		input logic [4:0] d, input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
		return {y[5:0], mo, d, h, mi, s};
	endfunction

	// ==========================================================
	// Monitor: pops the oldest note at each ready
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (wake_o === 1'b1)
			wake_cnt++;
		if (pready_o === 1'b1)
		begin
			if (notes.size() == 0)
				miss(32'h0000_0001, 32'h0000_0000);
			else
			begin
				note = notes.pop_front();
				chk(prdata_o & note.m, note.d & note.m);
				chk({31'h0, pslverr_o}, {31'h0, note.e});
			end
		end
		if (cycles == TIMEOUT)
		begin
			n_mismatch++;
			summarize();
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'h4f2e));
		repeat (10) @(posedge ref_clk_i);
		#1;
		rst_b_i = 1'b1;
		por_b_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rd(8'h18, snap(8'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00));
		rd(8'h38, 32'h0000_0000);
		$display("test power_up finished");
		// Alarm set-points with junk in reserved bits
		for (int b = 0; b < 6; b++)
		begin
			av[b] = 32'($urandom % lim[b]) + ((b == 3 || b == 4) ? 32'h1 : 32'h0);
			wr(8'(8'h1c + 4 * b), av[b] | (32'($urandom) << wd[b]));
		end
		for (int b = 0; b < 6; b++)
			rd(8'(8'h1c + 4 * b), av[b]);
		wr(8'h34, 32'($urandom));
		bus(1'b0, 8'h34, 32'h0, 32'h0000_003f, 32'hffff_ffc0, 1'b0);
		bus(1'b1, 8'h3c, ALL, 32'h0, ALL, 1'b1);
		bus(1'b0, 8'h3c, 32'h0, 32'h0, ALL, 1'b1);
		$display("test register_access finished");
		wr(8'h34, 32'h0000_003f);
		wr(8'h30, 32'h0000_00ff);
		set_time(32'h65, 32'h0c, 32'h1f, 32'h17, 32'h3b, 32'h3b);
		rd(8'h14, 32'h0000_0065);
		rd(8'h18, snap(8'h65, 4'hc, 5'h1f, 5'h17, 6'h3b, 6'h3b));
		wr(8'h38, 32'h0000_0004);
		rd(8'h38, 32'h0000_0000);
		tick(32'h0);
		rd(8'h18, snap(8'h66, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00));
		rd(8'h14, 32'h0000_0066);
		set_time(32'h00, 32'h02, 32'h1c, 32'h17, 32'h3b, 32'h3b);
		tick(32'h0);
		rd(8'h18, snap(8'h00, 4'h2, 5'h1d, 5'h00, 6'h00, 6'h00));
		set_time(32'h01, 32'h02, 32'h1c, 32'h17, 32'h3b, 32'h3b);
		tick(32'h0);
		rd(8'h18, snap(8'h01, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00));
		$display("test calendar finished");
		// Each enable alone on a wrong field, then all but that field
		set_time(32'h30, 32'h05, 32'h0a, 32'h07, 32'h14, 32'h1e);
		for (int b = 0; b < 6; b++)
			wr(8'(8'h1c + 4 * b), tv[b]);
		for (int b = 0; b < 6; b++)
		begin
			wr(8'(8'h1c + 4 * b), tv[b] + 32'h1);
			for (int m = 0; m < 2; m++)
			begin
				wr(8'h34, (m == 1) ? (32'h3f ^ (32'h1 << b)) : (32'h1 << b));
				wr(8'h00, 32'h0000_001e);
				tick(32'h3);
				wake_exp += m;
				chk({31'h0, alarm_irq_o}, 32'(m));
				rd(8'h38, {30'h0, m[0], 1'b1});
			end
			wr(8'(8'h1c + 4 * b), tv[b]);
		end
		$display("test alarm_match finished");
		wr(8'h38, 32'h0000_0001);
		rd(8'h38, 32'h0000_0003);
		wr(8'h38, 32'h0000_0002);
		rd(8'h38, 32'h0000_0000);
		wr(8'h34, 32'h0000_003f);
		wr(8'h00, 32'h0000_001e);
		tick(32'h0);
		wake_exp++;
		chk({31'h0, alarm_irq_o}, 32'h0);
		rd(8'h38, 32'h0000_0002);
		wr(8'h38, 32'h0000_0001);
		repeat (2) @(posedge ref_clk_i);
		chk({31'h0, alarm_irq_o}, 32'h1);
		wr(8'h38, 32'h0000_0003);
		repeat (2) @(posedge ref_clk_i);
		chk({31'h0, alarm_irq_o}, 32'h0);
		$display("test interrupt finished");
		@(posedge ref_clk_i);
		#1;
		apb_lock_i = 1'b1;
		wr(8'h1c, 32'h0000_0005);
		#1;
		apb_lock_i = 1'b0;
		rd(8'h1c, tv[0]);
		@(posedge ref_clk_i);
		#1;
		rst_b_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1;
		rst_b_i = 1'b1;
		rd(8'h30, tv[5]);
		rd(8'h38, 32'h0000_0001);
		rd(8'h18, snap(8'h30, 4'h5, 5'h0a, 5'h07, 6'h14, 6'h1f));
		$display("test lock_and_reset finished");
		chk(32'(wake_cnt), 32'(wake_exp));
		chk(32'(notes.size()), 32'h0);
		summarize();
	end

endmodule // rtcc_top_tb
`default_nettype wire
